// >>> verilog/ssr_rx.sv
// Overview of operation
// - A synchronizer flop left set after power-up blocks start pulses, so it is forced clear before reception.
// - Power-up reset issues one pulse that clears the last shift stage and sets the character control register.
// - After that reset the bit oscillator runs exactly one cycle, one shift pulse, then the control register clears.
// - Clearing the control register triggers the stop timer whose active output clears the synchronizer flop.
// - In test mode the serial input is the jack signal, or the open-line (space) condition without one, ignoring the modem.
// - In test mode the signal gate follows the stop timer instead of the synchronizer, regenerating blanks.
// - In test mode without a jack signal the synchronizer flop stays cleared.
// - Character length is selectable as five, six, seven or eight code levels.
// - A start transition is followed by a half-bit delay before the start pulse sets the control register.
// - The stop timer stays active about 2.9 ms for five-level and 0.95 ms for universal operation.
// - When the start bit reaches the last stage the next advance clears control, stops the oscillator, fires the timer.
`timescale 1ns/1ns
`include "ssr_cfg.svh"
module ssr_rx
  import ssr_pkg::*;
#(
  parameter int TIME_SCALE = 1
) (
  input  wire logic      i_clock,
  input  wire logic      i_reset,
  input  wire logic      i_line,
  input  wire logic      i_test_jack,
  input  wire logic      i_jack_present,
  input  ssr_cfg_t       i_cfg,
  output ssr_char_t      o_char,
  output logic           o_gate_open,
  output logic           o_sync_flop,
  output logic           o_stop_active,
  output logic           o_control
);
  // A scale above one shortens every timing count together, so that a bench can run quickly.
  localparam int BIT_CYC  = (`SSR_BIT_CYCLES) / TIME_SCALE;
  localparam int HALF_CYC = (`SSR_HALF_CYCLES) / TIME_SCALE;

  logic [1:0]  line_sync;
  logic [1:0]  jack_sync;
  logic        line_in;
  logic        line_prev;
  logic        gate_prev;
  logic        por_trigger;
  logic        char_control_reg;
  logic [8:0]  shift_reg;
  logic        last_shift_stage;
  logic        sync_flop;
  logic        por_pending;
  logic [31:0] osc_count;
  logic        advance;
  logic [31:0] delay_count;
  logic        start_delay_timer;
  logic        start_pulse;
  logic        timer_trigger;
  logic        stop_regen_timer;
  logic        timer_done;
  logic        input_signal_gate;
  logic [3:0]  bits_total;
  logic [31:0] stop_count;

  always_ff @(posedge i_clock) begin
    line_sync <= {line_sync[0], i_line};
    jack_sync <= {jack_sync[0], i_test_jack};
  end

  // Test mode sees a steady space, as an open line would give, unless a jack signal is plugged in.
  always_comb begin
    if (i_cfg.test_mode) begin
      line_in = i_jack_present ? jack_sync[1] : 1'b0;
    end else begin
      line_in = line_sync[1];
    end
  end

  always_comb begin
    bits_total = 4'h6 + {2'h0, i_cfg.length};
    stop_count = i_cfg.universal ? 32'((`SSR_STOPU_CYCLES) / TIME_SCALE) : 32'((`SSR_STOP5_CYCLES) / TIME_SCALE);
  end

  // Gate is open only while the selected source is idle.
  always_comb begin
    if (i_cfg.test_mode) begin
      input_signal_gate = !stop_regen_timer;
    end else begin
      input_signal_gate = !sync_flop && !stop_regen_timer;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      line_prev <= 1'b1;
      gate_prev <= 1'b1;
    end else begin
      line_prev <= line_in;
      gate_prev <= input_signal_gate;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      start_delay_timer <= 1'b0;
      delay_count       <= 32'h0;
      start_pulse       <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      // In test mode without a jack signal the line never falls, so the gate opening on a space starts the next blank.
      if (!start_delay_timer && !char_control_reg && input_signal_gate && !line_in &&
          (line_prev || (i_cfg.test_mode && !gate_prev))) begin
        start_delay_timer <= 1'b1;
        delay_count       <= 32'(HALF_CYC - 1);
      end else if (start_delay_timer) begin
        if (delay_count == 32'h0) begin
          start_delay_timer <= 1'b0;
          start_pulse       <= 1'b1;
        end else begin
          delay_count <= delay_count - 32'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      osc_count <= 32'h0;
      advance   <= 1'b0;
    end else begin
      advance <= 1'b0;
      if (!char_control_reg) begin
        osc_count <= 32'h0;
      end else if (osc_count == 32'(BIT_CYC - 1)) begin
        osc_count <= 32'h0;
        advance   <= 1'b1;
      end else begin
        osc_count <= osc_count + 32'h1;
      end
    end
  end

  // Start bit enters as a one; it marks the last stage after bits_total - 1 advances.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      shift_reg        <= 9'h0;
      last_shift_stage <= 1'b0;
    end else if (start_pulse) begin
      shift_reg        <= 9'h1;
      last_shift_stage <= 1'b0;
    end else if (advance) begin
      shift_reg        <= {shift_reg[7:0], line_in};
      last_shift_stage <= (shift_reg[bits_total - 4'h2] == 1'b1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      char_control_reg <= 1'b1;
      por_pending      <= 1'b1;
      timer_trigger    <= 1'b0;
      por_trigger      <= 1'b0;
    end else begin
      timer_trigger <= 1'b0;
      por_trigger   <= 1'b0;
      if (start_pulse) begin
        char_control_reg <= 1'b1;
      end else if (advance && (last_shift_stage || por_pending)) begin
        char_control_reg <= 1'b0;
        por_pending      <= 1'b0;
        por_trigger      <= por_pending;
        timer_trigger    <= 1'b1;
      end
    end
  end

  ssr_timer u_stop_timer (
    .i_clock  (i_clock),
    .i_reset  (i_reset),
    .i_trigger(timer_trigger),
    .i_count  (stop_count),
    .o_active (stop_regen_timer),
    .o_done   (timer_done)
  );

  // Set only if a space is present when the timer ends, which moves the next start later.
  always_ff @(posedge i_clock) begin
    if (i_reset || por_pending) begin
      sync_flop <= 1'b0;
    end else if (i_cfg.test_mode && !i_jack_present) begin
      sync_flop <= 1'b0;
    end else if (stop_regen_timer) begin
      sync_flop <= 1'b0;
    end else if (timer_done && !line_in) begin
      sync_flop <= 1'b1;
    end else if (line_in) begin
      sync_flop <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_char        <= '0;
      o_gate_open   <= 1'b0;
      o_sync_flop   <= 1'b0;
      o_stop_active <= 1'b0;
      o_control     <= 1'b0;
    end else begin
      o_char.valid  <= timer_trigger && !por_trigger;
      if (timer_trigger) begin
        o_char.data <= shift_reg[7:0];
      end
      o_gate_open   <= input_signal_gate;
      o_sync_flop   <= sync_flop;
      o_stop_active <= stop_regen_timer;
      o_control     <= char_control_reg;
    end
  end

  property p_start_delay;
    @(posedge i_clock) disable iff (i_reset) start_pulse |-> $past(start_delay_timer);
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("start pulse without delay");

  property p_test_sync;
    @(posedge i_clock) disable iff (i_reset)
      (i_cfg.test_mode && !i_jack_present) |=> !sync_flop;
  endproperty
  a_test_sync: assert property (p_test_sync) else $error("sync set in test");

  property p_clear_trigger;
    @(posedge i_clock) disable iff (i_reset) $fell(char_control_reg) |-> timer_trigger;
  endproperty
  a_clear_trigger: assert property (p_clear_trigger) else $error("no timer trigger");

  property p_timer_on;
    @(posedge i_clock) disable iff (i_reset) timer_trigger |=> stop_regen_timer;
  endproperty
  a_timer_on: assert property (p_timer_on) else $error("timer idle");

  property p_sync_clear;
    @(posedge i_clock) disable iff (i_reset) stop_regen_timer |=> !sync_flop;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync not cleared");

  property p_gate_test;
    @(posedge i_clock) disable iff (i_reset)
      i_cfg.test_mode |-> (input_signal_gate == !stop_regen_timer);
  endproperty
  a_gate_test: assert property (p_gate_test) else $error("gate source wrong");

  property p_osc_off;
    @(posedge i_clock) disable iff (i_reset) !char_control_reg |=> !advance;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator ran");

  property p_por_one;
    @(posedge i_clock) $fell(i_reset) |-> char_control_reg && por_pending;
  endproperty
  a_por_one: assert property (p_por_one) else $error("reset state wrong");
endmodule

// >>> verilog/ssr_cfg.svh
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH
`define SSR_CLK_HZ        250000000
`define SSR_BAUD          1050
`define SSR_BIT_CYCLES    ((`SSR_CLK_HZ) / (`SSR_BAUD))
`define SSR_HALF_CYCLES   ((`SSR_BIT_CYCLES) / 2)
`define SSR_STOP5_US      2900
`define SSR_STOPU_US      950
`define SSR_STOP5_CYCLES  ((`SSR_STOP5_US) * 250)
`define SSR_STOPU_CYCLES  ((`SSR_STOPU_US) * 250)
`define SSR_LEN_RESET     2'h0
`endif

// >>> verilog/ssr_pkg.sv
package ssr_pkg;
  typedef enum logic [1:0] {
    SSR_LEN5,
    SSR_LEN6,
    SSR_LEN7,
    SSR_LEN8
  } ssr_len_t;
  typedef struct packed {
    logic     test_mode;
    logic     universal;
    ssr_len_t length;
  } ssr_cfg_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ssr_char_t;
endpackage

// >>> verilog/ssr_timer.sv
`timescale 1ns/1ns
module ssr_timer (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_trigger,
  input  wire logic [31:0] i_count,
  output logic             o_active,
  output logic             o_done
);
  logic [31:0] remaining;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      remaining <= 32'h0;
      o_active  <= 1'b0;
      o_done    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_trigger) begin
        remaining <= i_count;
        o_active  <= 1'b1;
      end else if (o_active) begin
        if (remaining <= 32'h1) begin
          o_active <= 1'b0;
          o_done   <= 1'b1;
        end else begin
          remaining <= remaining - 32'h1;
        end
      end
    end
  end
endmodule

// >>> tb/ssr_modem.sv
`timescale 1ns/1ns
module ssr_modem
  import ssr_pkg::*;
#(
  parameter int BIT = 238095
) (
  input  wire logic       i_clock,
  input  wire logic       i_send,
  input  wire logic [7:0] i_data,
  output logic            o_line
);
  // Start space, eight bits least significant first, stop mark; the line idles at mark.
  logic [9:0] frame = 10'h3ff;
  logic [3:0] left  = 4'h0;
  int         cnt   = 0;
  assign o_line = frame[0];
  always_ff @(posedge i_clock) begin
    if (left == 4'h0) begin
      if (i_send) begin
        frame <= {1'b1, i_data, 1'b0};
        left  <= 4'ha;
        cnt   <= 0;
      end
    end else if (cnt == BIT - 1) begin
      frame <= {1'b1, frame[9:1]};
      left  <= left - 4'h1;
      cnt   <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// >>> tb/ssr_rx_tb.sv
`timescale 1ns/1ns
`include "ssr_cfg.svh"
module ssr_rx_tb
  import ssr_pkg::*;
;
  localparam int SCALE = 1000;
  localparam int BIT   = (`SSR_BIT_CYCLES) / SCALE;
  localparam int HALF  = (`SSR_HALF_CYCLES) / SCALE;
  localparam int STOP  = (`SSR_STOPU_CYCLES) / SCALE;
  logic      i_clock   = 1'b0;
  logic      i_reset   = 1'b1;
  logic      send      = 1'b0;
  logic      test_jack = 1'b1;
  ssr_cfg_t  cfg       = '{test_mode: 1'b0, universal: 1'b1, length: SSR_LEN5};
  ssr_char_t char_out;
  logic      line;
  logic      gate_open;
  logic      sync_flop;
  logic      stop_active;
  logic      control;
  int        err_count   = 0;
  int        checks_done = 0;
  int        cycles      = 0;
  int        valid_seen  = 0;

  always #2 i_clock = ~i_clock;

  ssr_modem #(.BIT(BIT)) ssr_modem_inst (.i_clock(i_clock), .i_send(send), .i_data(8'ha5), .o_line(line));

  ssr_rx #(.TIME_SCALE(SCALE)) ssr_rx_inst (.i_clock(i_clock), .i_reset(i_reset), .i_line(line), .i_test_jack(test_jack),
    .i_jack_present(1'b0), .i_cfg(cfg), .o_char(char_out), .o_gate_open(gate_open),
    .o_sync_flop(sync_flop), .o_stop_active(stop_active), .o_control(control));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Scaled counts keep the whole run to a few thousand cycles.
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (i_reset) begin
      valid_seen <= 0;
    end else if (char_out.valid === 1'b1) begin
      valid_seen <= valid_seen + 1;
    end
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
    if (cfg.test_mode && !i_reset) begin
      check("sync_flop in test", sync_flop, 32'h0);
    end
  end

  task automatic power_up();
    int n;
    n = 0;
    i_reset <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    check("control in reset", control, 32'h0);
    @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
    check("control after reset", control, 32'h1);
    check("sync after reset", sync_flop, 32'h0);
    while (control === 1'b1 && n < BIT + 100) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    check("one bit of control", (n > BIT - 10 && n < BIT + 10), 32'h1);
    @(posedge i_clock);
    #1;
    check("stop timer fired", stop_active, 32'h1);
    check("sync cleared", sync_flop, 32'h0);
    n = 0;
    while (stop_active === 1'b1 && n < STOP + 100) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    check("stop interval", (n > STOP - 10 && n < STOP + 10), 32'h1);
    check("gate open when idle", gate_open | cfg.test_mode, 32'h1);
    check("no char after reset", valid_seen, 32'h0);
  endtask

  task automatic blank_char();
    int n;
    n = 0;
    while (char_out.valid !== 1'b1 && n < 8 * BIT) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    check("blank char valid", char_out.valid, 32'h1);
    check("blank char data", char_out.data[4:0], 32'h0);
  endtask

  task automatic start_delay();
    int n;
    n = 0;
    @(posedge i_clock);
    send <= 1'b1;
    @(posedge i_clock);
    send <= 1'b0;
    #1;
    while (control === 1'b0 && n < BIT) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    check("half bit start", (n > HALF - 4 && n < HALF + 16), 32'h1);
  endtask

  initial begin
    power_up();
    start_delay();
    @(posedge i_clock);
    cfg.test_mode <= 1'b1;
    power_up();
    start_delay();
    blank_char();
    complete_run();
  end
endmodule
